// ---- dos_consts.svh ----
// Constants for the delayed one-shot pulse timer
`ifndef DOS_CONSTS_SVH
`define DOS_CONSTS_SVH
// Mode register field positions and wait one-shot select code
`define DOS_MODE_SEL_HI 5
`define DOS_MODE_SEL_LO 4
`define DOS_MODE_WR_CTRL 6
`define DOS_MODE_STOP 7
`define DOS_MODE_WAIT_ONESHOT 2'h3
// Waveform control field positions
`define DOS_WAVE_EXT_PRI 2
`define DOS_WAVE_POL 5
`define DOS_WAVE_TRIG_EN 6
`define DOS_WAVE_TRIG_EDGE 7
// Start register field
`define DOS_START_BIT 0
// Interrupt fields
`define DOS_IRQ_TZ_BIT 1
`define DOS_EDGE_EXT_BIT 0
`define DOS_IEN_EXT_BIT 2
// Count source selector codes
`define DOS_SRC_DIV2 2'h0
`define DOS_SRC_DIV16 2'h1
`define DOS_SRC_TY 2'h2
// Reset values and divider last counts
`define DOS_LATCH_RST 8'hff
`define DOS_REG_RST 8'h00
`define DOS_DIV2_LAST 4'h1
`define DOS_DIV16_LAST 4'hf
`endif

// ---- dos_partner.sv ----
// Trigger source and pulse load model for the one-shot timer
`timescale 1ns/1ps
module dos_partner (
    // Clock and observed pulse
    input wire logic clk,
    input wire logic pulse_output_pin,
    input wire logic idle_lvl,
    // Trigger pin towards the timer
    output logic external_trigger_pin
);
    int run = 0;
    int width = 0;
    int pulses = 0;
    // Pin rests high, as a pulled-up trigger line would
    initial external_trigger_pin = 1'b1;
    // Measure each excursion away from idle, in clock cycles
    always @(posedge clk) begin
        if (pulse_output_pin !== idle_lvl) begin
            run <= run + 1;
        end else if (run != 0) begin
            width <= run;
            pulses <= pulses + 1;
            run <= 0;
        end
    end
    // Park at the opposite level, then one edge; levels held long enough for any synchroniser
    task automatic make_edge(input logic rise);
        repeat (2) @(posedge clk);
        #2 external_trigger_pin = ~rise;
        repeat (6) @(posedge clk);
        #2 external_trigger_pin = rise;
    endtask : make_edge
endmodule : dos_partner

// ---- dos_pkg.sv ----
// Types for the delayed one-shot pulse timer
package dos_pkg;
    // Timer state along the pulse sequence
    typedef enum logic [1:0] {
        DOS_FREE = 2'h0,
        DOS_ARMED = 2'h1,
        DOS_PRIMARY = 2'h3,
        DOS_SECONDARY = 2'h2
    } dos_state_t;
    // Settings committed together by a primary latch write
    typedef struct packed {
        logic [7:0] primary;
        logic [7:0] secondary;
        logic extend;
    } dos_set_t;
endpackage : dos_pkg

// ---- dos_tick_gen.sv ----
// Count source selector producing a half-tick and full-tick strobe
`timescale 1ns/1ps
`include "dos_consts.svh"
module dos_tick_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Selection and companion underflow
    input wire logic [1:0] src_sel,
    input wire logic ty_underflow,
    // Strobes
    output logic half_tick,
    output logic tick
);
    logic [3:0] div_ff;
    logic [3:0] nxt_div;
    logic [3:0] last;

    // =========================================
    // Divider next state
    always_comb begin
        last = (src_sel == `DOS_SRC_DIV16) ? `DOS_DIV16_LAST : `DOS_DIV2_LAST;
        nxt_div = (div_ff >= last) ? 4'h0 : div_ff + 4'h1;
        if (src_sel == `DOS_SRC_TY) begin
            // Companion underflow has no midpoint, so no half tick
            tick = ty_underflow;
            half_tick = 1'b0;
        end else begin
            tick = (div_ff == last);
            half_tick = (div_ff == (last >> 1));
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            div_ff <= 4'h0;
        end else begin
            div_ff <= nxt_div;
        end
    end
endmodule : dos_tick_gen

// ---- dos_timer.sv ----
// Delayed one-shot pulse timer core
`timescale 1ns/1ps
`include "dos_consts.svh"
// Functional notes
// - Mode bits b5,b4 of mode register equal 11 selects delayed one-shot.
// - Count source is oscillator/2, oscillator/16 or timer Y underflow.
// - Every counter underflow raises the timer interrupt request flag.
// - Count-stop bit resets to zero, so timer runs after reset.
// - Clearing stop with latches loaded arms the timer to await a trigger.
// - Start bit write while armed counts primary, output stays idle.
// - Primary underflow reloads secondary and inverts the output together.
// - Next underflow restores idle, stops, and self-clears the start bit.
// - Polarity bit selects idle low/pulse high, or mirrored.
// - Trigger enable bit lets an external pin edge start the pulse.
// - Edge bit picks falling edge (zero) or rising edge (one).
// - Software start still works while pin trigger is selected.
// - Trigger edge raises pin interrupt when the enable bit is set and the edge select bit matches the edge bit.
// - Extension bit lengthens the pulse by half a divider period, or by a full period with the timer Y underflow source.
// - Primary latch write commits both latches and the extension bit for the next primary interval.
// - Secondary reads undefined; primary read shows count during secondary.
// - Primary and secondary latches are eight bits wide.
module dos_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Mode register write
    input wire logic mode_wr,
    input wire logic [7:0] mode_wdata,
    // Waveform control register write
    input wire logic wave_wr,
    input wire logic [7:0] wave_wdata,
    // Start register write
    input wire logic start_wr,
    input wire logic [7:0] start_wdata,
    // Latch writes
    input wire logic primary_wr,
    input wire logic secondary_wr,
    input wire logic [7:0] latch_wdata,
    // Interrupt configuration bits
    input wire logic [7:0] edge_select_reg,
    input wire logic [7:0] interrupt_enable_reg_1,
    // Count source
    input wire logic [1:0] src_sel,
    input wire logic ty_underflow,
    // External trigger pin
    input wire logic external_trigger_pin,
    // Status and data
    output logic [7:0] timer_yz_mode_reg,
    output logic [7:0] waveform_output_ctrl_reg,
    output logic [7:0] oneshot_start_reg,
    output logic [7:0] primary_read,
    output logic [7:0] secondary_read,
    output logic tz_irq_pulse,
    output logic ext_irq_pulse,
    output logic pulse_output_pin
);
    logic [7:0] mode_ff, nxt_mode;
    logic [7:0] wave_ff, nxt_wave;
    logic start_ff, nxt_start;
    dos_pkg::dos_set_t pend_ff, nxt_pend;
    dos_pkg::dos_set_t act_ff, nxt_act;
    logic commit_ff, nxt_commit;
    dos_pkg::dos_state_t state_ff, nxt_state;
    logic [7:0] cnt_ff, nxt_cnt;
    logic ext_pend_ff, nxt_ext_pend;
    logic out_ff, nxt_out;
    logic tzi_ff, nxt_tzi;
    logic exi_ff, nxt_exi;
    logic hold_ff, nxt_hold;
    logic [2:0] sync_ff;
    logic pin_ff, nxt_pin;
    logic half_tick, tick;
    logic mode_sel, stopped, pin_edge, trig, uf;

    // Count source selection
    dos_tick_gen u_tick (
        .clk(clk),
        .rst_b(rst_b),
        .src_sel(src_sel),
        .ty_underflow(ty_underflow),
        .half_tick(half_tick),
        .tick(tick)
    );

    // =========================================
    // Trigger pin synchroniser, three stages with agreement
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync_ff <= 3'h7; // Idle-high line, so leaving reset makes no false edge
            pin_ff <= 1'b1;
        end else begin
            sync_ff <= {sync_ff[1:0], external_trigger_pin};
            pin_ff <= nxt_pin;
        end
    end

    // Filtered pin level changes only once stages two and three agree
    always_comb begin
        nxt_pin = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : pin_ff;
        pin_edge = wave_ff[`DOS_WAVE_TRIG_EDGE] ? (nxt_pin & ~pin_ff) : (~nxt_pin & pin_ff);
    end

    // =========================================
    // Control state
    always_comb begin
        mode_sel = (mode_ff[`DOS_MODE_SEL_HI:`DOS_MODE_SEL_LO] == `DOS_MODE_WAIT_ONESHOT);
        stopped = mode_ff[`DOS_MODE_STOP];
        // Extension ends the pulse at the half tick after the last full count; the companion
        // source has no half tick, so there the next full tick ends it instead
        uf = act_ff.extend ? (hold_ff && (half_tick || tick)) : ((cnt_ff == 8'h00) && tick);
        nxt_mode = mode_wr ? mode_wdata : mode_ff;
        nxt_wave = wave_wr ? wave_wdata : wave_ff;
        nxt_pend = pend_ff;
        nxt_commit = commit_ff;
        nxt_act = act_ff;
        if (secondary_wr) begin
            nxt_pend.secondary = latch_wdata;
        end
        if (wave_wr) begin
            nxt_pend.extend = wave_wdata[`DOS_WAVE_EXT_PRI];
        end
        if (primary_wr) begin
            nxt_pend.primary = latch_wdata;
            nxt_commit = 1'b1;
        end
        // Pin trigger counts only when enabled and no pulse is in flight
        nxt_ext_pend = ext_pend_ff;
        if (pin_edge && wave_ff[`DOS_WAVE_TRIG_EN] && state_ff == dos_pkg::DOS_ARMED) begin
            nxt_ext_pend = 1'b1;
        end
        nxt_start = start_ff;
        if (start_wr && start_wdata[`DOS_START_BIT]) begin
            nxt_start = 1'b1;
        end
        trig = nxt_start || nxt_ext_pend;
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_out = out_ff;
        nxt_tzi = 1'b0;
        nxt_hold = hold_ff;
        unique case (state_ff)
            dos_pkg::DOS_FREE: begin
                // Wait mode arms instead of counting, so arming never raises a stray request
                if (mode_sel && !stopped) begin
                    nxt_state = dos_pkg::DOS_ARMED;
                end else if (tick && !stopped) begin
                    nxt_cnt = cnt_ff - 8'h01;
                    nxt_tzi = (cnt_ff == 8'h00);
                    if (cnt_ff == 8'h00) begin
                        nxt_cnt = act_ff.primary;
                    end
                end
                nxt_out = wave_ff[`DOS_WAVE_POL];
            end
            dos_pkg::DOS_ARMED: begin
                nxt_out = wave_ff[`DOS_WAVE_POL];
                if (!mode_sel || stopped) begin
                    nxt_state = dos_pkg::DOS_FREE;
                end else if (trig) begin
                    if (commit_ff) begin
                        nxt_act = pend_ff;
                        nxt_commit = primary_wr;
                        nxt_cnt = pend_ff.primary;
                    end else begin
                        nxt_cnt = act_ff.primary;
                    end
                    nxt_ext_pend = 1'b0;
                    nxt_state = dos_pkg::DOS_PRIMARY;
                end
            end
            dos_pkg::DOS_PRIMARY: begin
                if (tick) begin
                    nxt_cnt = cnt_ff - 8'h01;
                    if (cnt_ff == 8'h00) begin
                        nxt_cnt = act_ff.secondary;
                        nxt_out = ~wave_ff[`DOS_WAVE_POL];
                        nxt_tzi = 1'b1;
                        nxt_state = dos_pkg::DOS_SECONDARY;
                    end
                end
            end
            dos_pkg::DOS_SECONDARY: begin
                if (uf) begin
                    nxt_out = wave_ff[`DOS_WAVE_POL];
                    nxt_tzi = 1'b1;
                    nxt_start = 1'b0;
                    nxt_hold = 1'b0;
                    nxt_state = dos_pkg::DOS_ARMED;
                end else if (tick && cnt_ff == 8'h00) begin
                    // Only reached with extension: keep the level until the next half tick, or the next full tick on the companion source
                    nxt_hold = 1'b1;
                end else if (tick) begin
                    nxt_cnt = cnt_ff - 8'h01;
                end
            end
        endcase
        if (!mode_sel || stopped) begin
            nxt_start = 1'b0;
            nxt_ext_pend = 1'b0;
        end
        // Pin interrupt follows the selected edge when enabled
        nxt_exi = pin_edge && edge_select_reg[`DOS_EDGE_EXT_BIT] == wave_ff[`DOS_WAVE_TRIG_EDGE]
            && interrupt_enable_reg_1[`DOS_IEN_EXT_BIT];
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode_ff <= `DOS_REG_RST;
            wave_ff <= `DOS_REG_RST;
            start_ff <= 1'b0;
            pend_ff <= '{primary: `DOS_LATCH_RST, secondary: `DOS_LATCH_RST, extend: 1'b0};
            act_ff <= '{primary: `DOS_LATCH_RST, secondary: `DOS_LATCH_RST, extend: 1'b0};
            commit_ff <= 1'b0;
            state_ff <= dos_pkg::DOS_FREE;
            cnt_ff <= `DOS_LATCH_RST;
            ext_pend_ff <= 1'b0;
            out_ff <= 1'b0;
            tzi_ff <= 1'b0;
            exi_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            wave_ff <= nxt_wave;
            start_ff <= nxt_start;
            pend_ff <= nxt_pend;
            act_ff <= nxt_act;
            commit_ff <= nxt_commit;
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            ext_pend_ff <= nxt_ext_pend;
            out_ff <= nxt_out;
            tzi_ff <= nxt_tzi;
            exi_ff <= nxt_exi;
            hold_ff <= nxt_hold;
        end
    end

    // =========================================
    // Outputs straight from flip-flops, except the constant secondary read
    always_comb begin
        timer_yz_mode_reg = mode_ff;
        waveform_output_ctrl_reg = wave_ff;
        oneshot_start_reg = {7'h00, start_ff};
        primary_read = cnt_ff;
        secondary_read = `DOS_LATCH_RST;
        tz_irq_pulse = tzi_ff;
        ext_irq_pulse = exi_ff;
        pulse_output_pin = out_ff;
    end

    // =========================================
    // Checks
    a_idle_primary: assert property (@(posedge clk) disable iff (!rst_b)
        state_ff == dos_pkg::DOS_PRIMARY |-> out_ff == wave_ff[`DOS_WAVE_POL])
        else $error("Output moved in primary");
    a_invert_reload: assert property (@(posedge clk) disable iff (!rst_b)
        state_ff == dos_pkg::DOS_PRIMARY && tick && cnt_ff == 8'h00 |=> out_ff == ~$past(wave_ff[`DOS_WAVE_POL])
        && cnt_ff == $past(act_ff.secondary)) else $error("Secondary reload wrong");
    a_end_idle: assert property (@(posedge clk) disable iff (!rst_b)
        state_ff == dos_pkg::DOS_SECONDARY && uf |=> state_ff == dos_pkg::DOS_ARMED && !start_ff)
        else $error("End wrong");
    a_irq_uf: assert property (@(posedge clk) disable iff (!rst_b)
        state_ff == dos_pkg::DOS_SECONDARY && uf |=> tz_irq_pulse) else $error("Missing irq");
    a_arm_mode: assert property (@(posedge clk) disable iff (!rst_b)
        state_ff == dos_pkg::DOS_FREE && mode_sel && !stopped |=> state_ff == dos_pkg::DOS_ARMED)
        else $error("No arm");
    a_start_go: assert property (@(posedge clk) disable iff (!rst_b)
        state_ff == dos_pkg::DOS_ARMED && mode_sel && !stopped && start_wr && start_wdata[0]
        |=> state_ff == dos_pkg::DOS_PRIMARY) else $error("Start ignored");
    a_busy_ignore: assert property (@(posedge clk) disable iff (!rst_b)
        state_ff == dos_pkg::DOS_PRIMARY |=> !ext_pend_ff) else $error("Edge kept in pulse");
    a_reset_run: assert property (@(posedge clk)
        !rst_b |=> !mode_ff[7]) else $error("Stop bit set");

    // The last secondary count either ends the pulse or, with extension, holds it until the next half tick, or full tick on the companion source
    sequence s_sec_last;
        state_ff == dos_pkg::DOS_SECONDARY && cnt_ff == 8'h00 && tick && !hold_ff;
    endsequence
    // A lone pin edge while armed, with the mode still selected on the following cycle
    sequence s_pin_take;
        state_ff == dos_pkg::DOS_ARMED && mode_sel && !stopped && !nxt_start && !ext_pend_ff
        && pin_edge && wave_ff[`DOS_WAVE_TRIG_EN] ##1 mode_sel && !stopped;
    endsequence
    a_ext_hold: assert property (@(posedge clk) disable iff (!rst_b)
        s_sec_last ##0 act_ff.extend |=> state_ff == dos_pkg::DOS_SECONDARY && hold_ff)
        else $error("Extension lost");
    a_plain_end: assert property (@(posedge clk) disable iff (!rst_b)
        s_sec_last ##0 !act_ff.extend |=> state_ff == dos_pkg::DOS_ARMED
        && out_ff == $past(wave_ff[`DOS_WAVE_POL])) else $error("Pulse did not end");
    a_pin_arm: assert property (@(posedge clk) disable iff (!rst_b)
        s_pin_take |=> state_ff == dos_pkg::DOS_PRIMARY) else $error("Pin trigger lost");

    // Interrupt, commit and stop behaviour
    a_pin_irq: assert property (@(posedge clk) disable iff (!rst_b)
        pin_edge && interrupt_enable_reg_1[`DOS_IEN_EXT_BIT]
        && edge_select_reg[`DOS_EDGE_EXT_BIT] == wave_ff[`DOS_WAVE_TRIG_EDGE] |=> ext_irq_pulse)
        else $error("Pin interrupt missing");
    a_commit_load: assert property (@(posedge clk) disable iff (!rst_b)
        state_ff == dos_pkg::DOS_ARMED && mode_sel && !stopped && trig && commit_ff
        |=> act_ff == $past(pend_ff) && cnt_ff == $past(pend_ff.primary)) else $error("Commit not applied");
    a_stop_hold: assert property (@(posedge clk) disable iff (!rst_b)
        state_ff == dos_pkg::DOS_FREE && stopped |=> $stable(cnt_ff)) else $error("Count ran while stopped");
endmodule : dos_timer

// ---- testbench.sv ----
// Self-checking bench for the delayed one-shot pulse timer
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] wsel = 5'h0;
    logic [7:0] wdat = 8'h00;
    logic [7:0] edge_select_reg = 8'h00;
    logic [7:0] interrupt_enable_reg_1 = 8'h00;
    logic [1:0] src_sel = 2'h0;
    logic ty_underflow = 1'b0;
    logic idle_lvl = 1'b0;
    logic external_trigger_pin;
    logic [7:0] timer_yz_mode_reg, waveform_output_ctrl_reg, oneshot_start_reg, primary_read, secondary_read;
    logic tz_irq_pulse, ext_irq_pulse, pulse_output_pin;
    int bad_count = 0;
    int n_tests = 0;
    int tz_cnt = 0;
    int ext_cnt = 0;
    int cyc = 0;
    int ty_ph = 0;
    // ============================================================
    // Design, trigger source and load
    dos_timer i_dut (.clk(clk), .rst_b(rst_b), .mode_wr(wsel[0]), .mode_wdata(wdat), .wave_wr(wsel[1]),
        .wave_wdata(wdat), .start_wr(wsel[4]), .start_wdata(wdat), .primary_wr(wsel[2]),
        .secondary_wr(wsel[3]), .latch_wdata(wdat), .edge_select_reg(edge_select_reg),
        .interrupt_enable_reg_1(interrupt_enable_reg_1), .src_sel(src_sel), .ty_underflow(ty_underflow),
        .external_trigger_pin(external_trigger_pin), .timer_yz_mode_reg(timer_yz_mode_reg),
        .waveform_output_ctrl_reg(waveform_output_ctrl_reg), .oneshot_start_reg(oneshot_start_reg),
        .primary_read(primary_read), .secondary_read(secondary_read), .tz_irq_pulse(tz_irq_pulse),
        .ext_irq_pulse(ext_irq_pulse), .pulse_output_pin(pulse_output_pin));
    dos_partner i_part (.clk(clk), .pulse_output_pin(pulse_output_pin), .idle_lvl(idle_lvl),
        .external_trigger_pin(external_trigger_pin));
    // ============================================================
    // Clock, companion underflow every 5 cycles, event counters, watchdog
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        #2;
        ty_ph = (ty_ph == 4) ? 0 : ty_ph + 1;
        ty_underflow = (ty_ph == 0);
    end
    always @(posedge clk) begin
        tz_cnt <= tz_cnt + (tz_irq_pulse === 1'b1);
        ext_cnt <= ext_cnt + (ext_irq_pulse === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            $display("[FAIL] %0t run hung", $time);
            results();
        end
    end
    // ============================================================
    // Compare tasks and closing report
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t value %h, expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_cnt(input int got, input int exp);
        n_tests++;
        if (got != exp) begin
            bad_count++;
            $display("[FAIL] %0t count %0d, expected %0d", $time, got, exp);
        end
    endtask : chk_cnt
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    // One write strobe per call; the strobe drops a full cycle before the next can rise
    task automatic wr(input int sel, input logic [7:0] d);
        @(posedge clk);
        #2;
        wsel = 5'h1 << sel;
        wdat = d;
        @(posedge clk);
        #2;
        wsel = 5'h0;
    endtask : wr
    // ============================================================
    // Reset state, then the timer must already be counting
    task automatic t_reset;
        chk_val(timer_yz_mode_reg, 8'h00);
        chk_val(waveform_output_ctrl_reg, 8'h00);
        chk_val(oneshot_start_reg, 8'h00);
        chk_val(pulse_output_pin, 8'h00);
        chk_val(^secondary_read !== 1'bx, 8'h01);
        repeat (10) @(posedge clk);
        #2;
        chk_val(primary_read !== 8'hff, 8'h01);
    endtask : t_reset
    // One pulse; trig 0 software, 1 falling pin, 2 rising pin, 3 software with pin enabled; tp ticks in cycles
    task automatic t_shot(input logic pol, ext, input logic [1:0] src, input logic [7:0] p, s,
            input int trig, input int tp);
        int n0, tz0, ex0, n;
        @(posedge clk);
        #2;
        src_sel = src;
        edge_select_reg = {7'h0, trig == 2};
        interrupt_enable_reg_1 = 8'h04;
        wr(0, 8'hf0);
        wr(1, {trig == 2, trig != 0, pol, 2'h0, ext, 2'h0});
        idle_lvl = pol;
        wr(3, s);
        wr(2, p);
        wr(0, 8'h70);
        n0 = i_part.pulses;
        tz0 = tz_cnt;
        ex0 = ext_cnt;
        if (trig == 0 || trig == 3) wr(4, 8'h01);
        else i_part.make_edge(trig == 2);
        n = 0;
        while (pulse_output_pin === pol && n < 3000) begin
            @(posedge clk);
            #2;
            n++;
        end
        chk_cnt(n < 3000, 1);
        chk_val(primary_read, s);
        chk_cnt(ext_cnt - ex0, trig == 1 || trig == 2);
        if (trig == 1 || trig == 2) i_part.make_edge(trig == 2);
        n = 0;
        while (i_part.pulses == n0 && n < 3000) begin
            @(posedge clk);
            #2;
            n++;
        end
        chk_cnt(n < 3000, 1);
        repeat (4 * tp * (p + 2)) @(posedge clk);
        #2;
        chk_cnt(i_part.width, tp * (s + 1) + ext * (tp / 2));
        chk_cnt(i_part.pulses - n0, 1);
        chk_cnt(tz_cnt - tz0, 2);
        chk_val(oneshot_start_reg[0], 8'h00);
        chk_val(pulse_output_pin, pol);
    endtask : t_shot
    // ============================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        #2;
        rst_b = 1'b1;
        t_reset();
        t_shot(1'b0, 1'b0, 2'h0, 8'h03, 8'h04, 0, 2);
        t_shot(1'b0, 1'b0, 2'h0, 8'h00, 8'h00, 0, 2);
        t_shot(1'b1, 1'b0, 2'h0, 8'h02, 8'h05, 0, 2);
        t_shot(1'b0, 1'b1, 2'h0, 8'h03, 8'h04, 0, 2);
        t_shot(1'b0, 1'b0, 2'h1, 8'h01, 8'h02, 0, 16);
        t_shot(1'b0, 1'b0, 2'h2, 8'h01, 8'h03, 0, 5);
        t_shot(1'b0, 1'b0, 2'h0, 8'h02, 8'h14, 1, 2);
        t_shot(1'b1, 1'b0, 2'h0, 8'h02, 8'h14, 2, 2);
        t_shot(1'b0, 1'b0, 2'h0, 8'h02, 8'h05, 3, 2);
        results();
    end
endmodule : testbench
